// File: common/fma_pkg.sv
// shared constants, register map and state types for the fault monitor and converter scheduler
package fma_pkg;

	// register offsets
	localparam logic [7:0] REG_PHASE_LIMIT_GAIN_A = 8'h21;
	localparam logic [7:0] REG_PHASE_LIMIT_GAIN_B = 8'h22;
	localparam logic [7:0] REG_TOTAL_CURRENT_DEGLITCH = 8'h23;
	localparam logic [7:0] REG_TOTAL_CURRENT_TRIP_LEVEL = 8'h24;
	localparam logic [7:0] REG_PROTECTION_ENABLES = 8'h29;
	localparam logic [7:0] REG_FAULT_FLAGS = 8'h2a;
	localparam logic [7:0] REG_PHASE_LIMIT_FLAGS = 8'h2b;
	localparam logic [7:0] REG_TOTAL_CURRENT_RESULT = 8'h2e;
	localparam logic [7:0] REG_OUTPUT_VOLTAGE_RESULT = 8'h2f;
	localparam logic [7:0] REG_TEMPERATURE_RESULT = 8'h30;
	localparam logic [7:0] REG_TOTAL_CURRENT_AVERAGING = 8'h31;
	localparam logic [7:0] REG_OUTPUT_VOLTAGE_AVERAGING = 8'h32;
	localparam logic [7:0] REG_TEMPERATURE_TIMING = 8'h33;
	localparam logic [7:0] REG_PHASE_LIMIT_DISABLE = 8'h4d;

	// field positions
	localparam int FLAG_TOTAL_CURRENT_BIT = 2;
	localparam int FLAG_TEMP_SENSE_BIT = 4;

	// reset values
	localparam logic [7:0] RST_PROTECTION_ENABLES = 8'h1f;
	localparam logic [7:0] RST_CONFIG = 8'h00;

	// converter channels, in result-register order
	localparam logic [1:0] CH_CURRENT = 2'h0;
	localparam logic [1:0] CH_VOLTAGE = 2'h1;
	localparam logic [1:0] CH_TEMP = 2'h2;

	// timing, in ns, and derived cycle counts at the reference clock
	localparam int CLK_MHZ = 40;
	localparam int CURRENT_PERIOD_NS = 13500;
	localparam int CURRENT_FAST_PERIOD_NS = 6750;
	localparam int SLOW_PERIOD_NS = 40500;
	localparam int CURRENT_PERIOD_CYC = CURRENT_PERIOD_NS * CLK_MHZ / 1000;
	localparam int CURRENT_FAST_CYC = CURRENT_FAST_PERIOD_NS * CLK_MHZ / 1000;
	localparam int SLOW_PERIOD_CYC = SLOW_PERIOD_NS * CLK_MHZ / 1000;
	localparam int DEGLITCH0_NS = 2000;
	localparam int DEGLITCH1_NS = 5000;
	localparam int DEGLITCH2_NS = 10000;
	localparam int DEGLITCH3_NS = 20000;
	localparam int DEGLITCH0_CYC = (DEGLITCH0_NS * CLK_MHZ + 999) / 1000;
	localparam int DEGLITCH1_CYC = (DEGLITCH1_NS * CLK_MHZ + 999) / 1000;
	localparam int DEGLITCH2_CYC = (DEGLITCH2_NS * CLK_MHZ + 999) / 1000;
	localparam int DEGLITCH3_CYC = (DEGLITCH3_NS * CLK_MHZ + 999) / 1000;

	// temperature-sense shutdown level as an 8-bit code
	localparam int TEMP_SHUTDOWN_MV = 800;
	localparam int ADC_FULL_SCALE_MV = 2000;
	localparam logic [7:0] TEMP_SHUTDOWN_CODE = 8'(TEMP_SHUTDOWN_MV * 256 / ADC_FULL_SCALE_MV);

	// converter request carrier
	typedef struct packed {
		logic start;
		logic [1:0] chan;
	} fma_conv_req_t;

	// serial register port states
	typedef enum logic [3:0] {
		SER_IDLE = 4'h0,
		SER_ADDR = 4'h1,
		SER_ACK_ADDR = 4'h2,
		SER_REG = 4'h3,
		SER_ACK_REG = 4'h4,
		SER_WDATA = 4'h5,
		SER_ACK_WDATA = 4'h6,
		SER_RDATA = 4'h7,
		SER_ACK_RDATA = 4'h8
	} fma_ser_state_t;

	// whole state of the block
	typedef struct packed {
		fma_ser_state_t st;
		logic [3:0] bitc;
		logic [7:0] shift;
		logic rw;
		logic ack_ok;
		logic [7:0] ptr;
		logic sda_drv;
		logic scl_q;
		logic sda_q;
		logic [7:0] gain_a;
		logic [7:0] gain_b;
		logic [7:0] tc_dg;
		logic [7:0] tc_trip;
		logic [7:0] prot_en;
		logic [7:0] tc_avg;
		logic [7:0] vs_avg;
		logic [7:0] temp_tim;
		logic [7:0] pl_dis;
		logic flt_t;
		logic flt_c;
		logic sd;
		logic pg;
		logic sched_on;
		logic [10:0] tc_tmr;
		logic [10:0] slow_tmr;
		logic [2:0] pend;
		logic busy;
		fma_conv_req_t req;
		logic [2:0][10:0] acc;
		logic [2:0][2:0] cnt;
		logic [2:0][7:0] res;
		logic over_t;
		logic over_c;
		logic [10:0] dg_t;
		logic [10:0] dg_c;
		logic [7:0] pl_flags;
	} fma_state_t;

	// deglitch length for a 2-bit select
	function automatic logic [10:0] fma_dg_cycles(input logic [1:0] sel);
		case (sel)
			2'h0: fma_dg_cycles = 11'(DEGLITCH0_CYC);
			2'h1: fma_dg_cycles = 11'(DEGLITCH1_CYC);
			2'h2: fma_dg_cycles = 11'(DEGLITCH2_CYC);
			default: fma_dg_cycles = 11'(DEGLITCH3_CYC);
		endcase
	endfunction : fma_dg_cycles

endpackage : fma_pkg

// File: hdl/fma_fault_monitor.sv
// fault monitor, phase limit and converter scheduler with a serial register port
`timescale 1ns/1ps

module fma_fault_monitor
	import fma_pkg::*;
#(
	parameter logic [6:0] DEVICE_ADDR = 7'h20 // arbitrary serial address
)(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic enable_in,
	input wire logic output_at_reference,
	input wire logic conv_done,
	input wire logic [7:0] conv_data,
	input wire logic [7:0] phase_over_limit,
	input wire logic scl_in,
	input wire logic sda_in,
	output fma_conv_req_t conv_req,
	output logic pwm_tristate,
	output logic power_good_out,
	output logic power_good_oe,
	output logic [7:0] phase_block,
	output logic [15:0] phase_gain,
	output logic sda_out,
	output logic sda_oe
);

	fma_state_t s;
	fma_state_t next_s;
	logic pl_disabled;
	logic scl_rise;
	logic scl_fall;
	logic ser_start;
	logic ser_stop;
	logic [7:0] rd_data;

	// readback mux; unmapped offsets read as zero
	always_comb begin
		case (s.ptr)
			REG_PHASE_LIMIT_GAIN_A: rd_data = s.gain_a;
			REG_PHASE_LIMIT_GAIN_B: rd_data = s.gain_b;
			REG_TOTAL_CURRENT_DEGLITCH: rd_data = s.tc_dg;
			REG_TOTAL_CURRENT_TRIP_LEVEL: rd_data = s.tc_trip;
			REG_PROTECTION_ENABLES: rd_data = s.prot_en;
			REG_FAULT_FLAGS: rd_data = {3'h0, s.flt_t, 1'h0, s.flt_c, 2'h0};
			REG_PHASE_LIMIT_FLAGS: rd_data = s.pl_flags;
			REG_TOTAL_CURRENT_RESULT: rd_data = s.res[CH_CURRENT];
			REG_OUTPUT_VOLTAGE_RESULT: rd_data = s.res[CH_VOLTAGE];
			REG_TEMPERATURE_RESULT: rd_data = s.res[CH_TEMP];
			REG_TOTAL_CURRENT_AVERAGING: rd_data = s.tc_avg;
			REG_OUTPUT_VOLTAGE_AVERAGING: rd_data = s.vs_avg;
			REG_TEMPERATURE_TIMING: rd_data = s.temp_tim;
			REG_PHASE_LIMIT_DISABLE: rd_data = s.pl_dis;
			default: rd_data = 8'h00;
		endcase
	end

	// line events, taken from the registered previous levels
	assign scl_rise = scl_in && !s.scl_q;
	assign scl_fall = !scl_in && s.scl_q;
	assign ser_start = scl_in && s.scl_q && s.sda_q && !sda_in;
	assign ser_stop = scl_in && s.scl_q && !s.sda_q && sda_in;
	assign pl_disabled = s.pl_dis[1:0] != 2'h0;

	// next-state logic for the whole block
	always_comb begin
		logic [10:0] dg_lim_t;
		logic [10:0] dg_lim_c;
		logic [10:0] tc_lim;
		logic [10:0] sum;
		logic [1:0] sel;
		logic det_t;
		logic det_c;
		dg_lim_t = fma_dg_cycles(s.temp_tim[1:0]);
		dg_lim_c = fma_dg_cycles(s.tc_dg[1:0]);
		tc_lim = s.flt_c ? 11'(CURRENT_FAST_CYC) : 11'(CURRENT_PERIOD_CYC);
		sum = 11'h000;
		sel = 2'h0;
		next_s = s;
		next_s.scl_q = scl_in;
		next_s.sda_q = sda_in;
		next_s.req.start = 1'b0;

		// serial register port: bytes in msb first, ack on the ninth clock
		if (ser_start) begin
			next_s.st = SER_ADDR;
			next_s.bitc = 4'h0;
			next_s.sda_drv = 1'b0;
		end else if (ser_stop) begin
			next_s.st = SER_IDLE;
			next_s.sda_drv = 1'b0;
		end else if (scl_rise) begin
			case (s.st)
				SER_ADDR, SER_REG, SER_WDATA: begin
					next_s.shift = {s.shift[6:0], sda_in};
					next_s.bitc = s.bitc + 4'h1;
				end
				SER_RDATA: begin
					next_s.bitc = s.bitc + 4'h1;
				end
				SER_ACK_RDATA: begin
					next_s.ack_ok = !sda_in;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (s.st)
				SER_ADDR: begin
					if (s.bitc == 4'h8) begin
						next_s.bitc = 4'h0;
						if (s.shift[7:1] == DEVICE_ADDR) begin
							next_s.rw = s.shift[0];
							next_s.st = SER_ACK_ADDR;
							next_s.sda_drv = 1'b1;
						end else begin
							next_s.st = SER_IDLE;
						end
					end
				end
				SER_ACK_ADDR: begin
					if (s.rw) begin
						next_s.st = SER_RDATA;
						next_s.shift = rd_data;
						next_s.sda_drv = !rd_data[7];
					end else begin
						next_s.st = SER_REG;
						next_s.sda_drv = 1'b0;
					end
				end
				SER_REG: begin
					if (s.bitc == 4'h8) begin
						next_s.ptr = s.shift;
						next_s.bitc = 4'h0;
						next_s.st = SER_ACK_REG;
						next_s.sda_drv = 1'b1;
					end
				end
				SER_ACK_REG, SER_ACK_WDATA: begin
					next_s.st = SER_WDATA;
					next_s.sda_drv = 1'b0;
				end
				SER_WDATA: begin
					if (s.bitc == 4'h8) begin
						// read-only offsets fall through with no effect
						case (s.ptr)
							REG_PHASE_LIMIT_GAIN_A: next_s.gain_a = s.shift;
							REG_PHASE_LIMIT_GAIN_B: next_s.gain_b = s.shift;
							REG_TOTAL_CURRENT_DEGLITCH: next_s.tc_dg = s.shift;
							REG_TOTAL_CURRENT_TRIP_LEVEL: next_s.tc_trip = s.shift;
							REG_PROTECTION_ENABLES: next_s.prot_en = s.shift;
							REG_TOTAL_CURRENT_AVERAGING: next_s.tc_avg = s.shift;
							REG_OUTPUT_VOLTAGE_AVERAGING: next_s.vs_avg = s.shift;
							REG_TEMPERATURE_TIMING: next_s.temp_tim = s.shift;
							REG_PHASE_LIMIT_DISABLE: next_s.pl_dis = s.shift;
							default: begin
							end
						endcase
						next_s.ptr = s.ptr + 8'h01;
						next_s.bitc = 4'h0;
						next_s.st = SER_ACK_WDATA;
						next_s.sda_drv = 1'b1;
					end
				end
				SER_RDATA: begin
					if (s.bitc == 4'h8) begin
						next_s.st = SER_ACK_RDATA;
						next_s.sda_drv = 1'b0;
						next_s.ptr = s.ptr + 8'h01;
					end else begin
						next_s.sda_drv = !s.shift[6];
						next_s.shift = {s.shift[6:0], 1'b0};
					end
				end
				SER_ACK_RDATA: begin
					next_s.bitc = 4'h0;
					if (s.ack_ok) begin
						next_s.st = SER_RDATA;
						next_s.shift = rd_data;
						next_s.sda_drv = !rd_data[7];
					end else begin
						next_s.st = SER_IDLE;
					end
				end
				default: begin
					next_s.st = SER_IDLE;
					next_s.sda_drv = 1'b0;
				end
			endcase
		end

		// live per-phase limit flags; comparator delay dominates the one-cycle register
		next_s.pl_flags = phase_over_limit;

		// scheduler starts only once power good has been seen high
		if (!enable_in) begin
			next_s.sched_on = 1'b0;
		end else if (s.pg && !s.sched_on) begin
			next_s.sched_on = 1'b1;
			next_s.pend = 3'h7;
			next_s.tc_tmr = 11'h000;
			next_s.slow_tmr = 11'h000;
		end

		if (!s.sched_on) begin
			next_s.busy = 1'b0;
			next_s.over_t = 1'b0;
			next_s.over_c = 1'b0;
		end else begin
			// result handling: averaging on every raw sample, fault compare on raw current and temperature samples
			if (conv_done && s.busy) begin
				next_s.busy = 1'b0;
				for (int i = 0; i < 3; i++) begin
					if (s.req.chan == 2'(i)) begin
						sel = (i == 0) ? s.tc_avg[1:0] : (i == 1) ? s.vs_avg[1:0] : s.temp_tim[1:0];
						sum = s.acc[i] + {3'h0, conv_data};
						if (s.cnt[i] == 3'((4'h1 << sel) - 4'h1)) begin
							next_s.res[i] = 8'(sum >> sel);
							next_s.acc[i] = 11'h000;
							next_s.cnt[i] = 3'h0;
						end else begin
							next_s.acc[i] = sum;
							next_s.cnt[i] = s.cnt[i] + 3'h1;
						end
					end
				end
				if (s.req.chan == CH_CURRENT) begin
					next_s.over_c = conv_data > {s.tc_trip[5:0], 2'h0};
				end
				if (s.req.chan == CH_TEMP) begin
					next_s.over_t = conv_data > TEMP_SHUTDOWN_CODE;
				end
			end

			// issue one pending conversion at a time, current first
			if (!next_s.busy && s.pend != 3'h0) begin
				next_s.busy = 1'b1;
				next_s.req.start = 1'b1;
				if (s.pend[0]) begin
					next_s.req.chan = CH_CURRENT;
					next_s.pend[0] = 1'b0;
				end else if (s.pend[1]) begin
					next_s.req.chan = CH_VOLTAGE;
					next_s.pend[1] = 1'b0;
				end else begin
					next_s.req.chan = CH_TEMP;
					next_s.pend[2] = 1'b0;
				end
			end

			// interval timers; a timer set beats the issue clear above
			if (s.tc_tmr >= tc_lim - 11'h001) begin
				next_s.tc_tmr = 11'h000;
				next_s.pend[0] = 1'b1;
			end else begin
				next_s.tc_tmr = s.tc_tmr + 11'h001;
			end
			if (s.slow_tmr >= 11'(SLOW_PERIOD_CYC - 1)) begin
				next_s.slow_tmr = 11'h000;
				next_s.pend[2:1] = 2'h3;
			end else begin
				next_s.slow_tmr = s.slow_tmr + 11'h001;
			end
		end

		// deglitch: count uninterrupted over-level cycles, restart on any drop
		next_s.dg_t = s.over_t ? ((s.dg_t == 11'h7ff) ? s.dg_t : s.dg_t + 11'h001) : 11'h000;
		next_s.dg_c = s.over_c ? ((s.dg_c == 11'h7ff) ? s.dg_c : s.dg_c + 11'h001) : 11'h000;
		det_t = s.over_t && (s.dg_t >= dg_lim_t);
		det_c = s.over_c && (s.dg_c >= dg_lim_c);

		// latched faults: held until enable low releases them, and enable low wins over detection
		next_s.flt_t = det_t || (s.flt_t && enable_in);
		next_s.flt_c = det_c || (s.flt_c && enable_in);
		if (!enable_in) begin
			next_s.flt_t = 1'b0;
			next_s.flt_c = 1'b0;
		end
		// enables gate shutdown only, flags stay honest
		// uses the enables as they stand after this edge, so a write never lags shutdown
		next_s.sd = (next_s.flt_t && next_s.prot_en[FLAG_TEMP_SENSE_BIT])
			|| (next_s.flt_c && next_s.prot_en[FLAG_TOTAL_CURRENT_BIT]);

		// power good latches at reference and drops on shutdown or enable loss
		next_s.pg = enable_in && !next_s.sd && (s.pg || output_at_reference);
	end

	// single state register; clock enable freezes everything
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.st <= SER_IDLE;
			s.scl_q <= 1'b1;
			s.sda_q <= 1'b1;
			s.prot_en <= RST_PROTECTION_ENABLES;
			s.gain_a <= RST_CONFIG;
			s.gain_b <= RST_CONFIG;
			s.pl_dis <= RST_CONFIG;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// outputs
	assign conv_req = s.req;
	assign pwm_tristate = s.sd;
	assign power_good_out = s.pg;
	assign power_good_oe = !s.pg; // open drain pulls low while not good
	assign phase_block = pl_disabled ? 8'h00 : s.pl_flags;
	assign phase_gain = {s.gain_b, s.gain_a};
	assign sda_out = 1'b0;
	assign sda_oe = s.sda_drv;

	a_temp_fault_latch: assert property (@(posedge ref_clk) disable iff (rst)
		s.flt_t && enable_in && clk_en |=> s.flt_t) else $error("temp fault released");
	a_fault_release: assert property (@(posedge ref_clk) disable iff (rst)
		!enable_in && clk_en |=> !s.flt_c && !s.flt_t && !power_good_out)
		else $error("fault not released by enable low");
	a_temp_shutdown: assert property (@(posedge ref_clk) disable iff (rst)
		s.flt_t && s.prot_en[FLAG_TEMP_SENSE_BIT] |-> pwm_tristate && !power_good_out)
		else $error("temp fault without shutdown");
	a_curr_flag_only: assert property (@(posedge ref_clk) disable iff (rst)
		s.flt_c && !s.flt_t && !s.prot_en[FLAG_TOTAL_CURRENT_BIT] |-> !pwm_tristate)
		else $error("disabled current protection shut down");
	a_deglitch_restart: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && !s.over_c |=> s.dg_c == 11'h000) else $error("deglitch not restarted");
	a_temp_no_early: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && enable_in && !s.flt_t && !(s.over_t && s.dg_t >= fma_dg_cycles(s.temp_tim[1:0]))
		|=> !s.flt_t) else $error("temp fault before deglitch");
	a_phase_block: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && phase_over_limit[0] && next_s.pl_dis[1:0] == 2'h0 |=> phase_block[0])
		else $error("phase not blocked");
	a_sched_idle: assert property (@(posedge ref_clk) disable iff (rst)
		!s.sched_on |-> !conv_req.start) else $error("conversion before power good");
	a_fast_interval: assert property (@(posedge ref_clk) disable iff (rst)
		s.flt_c && s.sched_on |=> s.tc_tmr <= 11'(CURRENT_FAST_CYC))
		else $error("current interval not shortened");

endmodule : fma_fault_monitor

// File: verif/fma_adc_model.sv
// converter stand-in: answers each request after a fixed latency with the channel's code
`timescale 1ns/1ps
module fma_adc_model
	import fma_pkg::*;
#(
	parameter int LATENCY = 6
)(
	input wire logic ref_clk,
	input wire logic rst,
	input fma_conv_req_t conv_req,
	input wire logic [2:0][7:0] codes,
	output logic conv_done,
	output logic [7:0] conv_data
);
	int cnt;
	logic [1:0] chan;

	// data toggles outside the valid cycle so a sample one cycle late never matches by luck
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			chan <= 2'h0;
			conv_done <= 1'b0;
			conv_data <= 8'h00;
		end else begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			if (conv_req.start) begin
				cnt <= LATENCY;
				chan <= conv_req.chan;
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
				if (cnt == 1) begin
					conv_done <= 1'b1;
					conv_data <= codes[chan];
				end
			end
		end
	end
endmodule : fma_adc_model

// File: verif/fault_monitor_adc_test.sv
// self-checking bench for the fault monitor: serial register tasks and protection scenarios
`timescale 1ns/1ps
module fault_monitor_adc_test;
	import fma_pkg::*;
	localparam logic [6:0] ADDR = 7'h20;
	localparam logic [7:0] TEMP_OVER = TEMP_SHUTDOWN_CODE + 8'h01;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic enable_in = 1'b0;
	logic at_ref = 1'b0;
	logic scl_h = 1'b1;
	logic sda_h = 1'b1;
	logic [7:0] over = 8'h00;
	logic [2:0][7:0] codes = {8'h30, 8'h50, 8'h20};
	fma_conv_req_t conv_req;
	logic conv_done, pwm_tristate, power_good_out, power_good_oe, sda_out, sda_oe;
	logic [7:0] conv_data, phase_block;
	logic [15:0] phase_gain;
	wire logic sda_wire = ~((~sda_h) | sda_oe);
	int bad_count = 0, cmp_count = 0, cyc = 0, cur_last = 0, cur_gap = 0, starts = 0;

	fma_fault_monitor #(.DEVICE_ADDR(ADDR)) dut (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
		.enable_in(enable_in), .output_at_reference(at_ref), .conv_done(conv_done),
		.conv_data(conv_data), .phase_over_limit(over), .scl_in(scl_h), .sda_in(sda_wire),
		.conv_req(conv_req), .pwm_tristate(pwm_tristate), .power_good_out(power_good_out),
		.power_good_oe(power_good_oe), .phase_block(phase_block), .phase_gain(phase_gain),
		.sda_out(sda_out), .sda_oe(sda_oe));
	fma_adc_model adc (.ref_clk(ref_clk), .rst(rst), .conv_req(conv_req), .codes(codes),
		.conv_done(conv_done), .conv_data(conv_data));

	initial forever #12.5 ref_clk = ~ref_clk;

	// spacing between current-channel requests, for the interval checks
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (conv_req.start === 1'b1) begin
			starts <= starts + 1;
			if (conv_req.chan === CH_CURRENT) begin
				cur_gap <= cyc - cur_last;
				cur_last <= cyc;
			end
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one serial bit; clock high for four clocks and low for eight keeps well above the port's minimum
	task automatic bit_io(input logic b, output logic r);
		sda_h <= b;
		tick(4);
		scl_h <= 1'b1;
		tick(4);
		r = sda_wire;
		scl_h <= 1'b0;
		tick(4);
	endtask : bit_io

	// also serves as repeated start, since data only moves while the clock is low
	task automatic start_cond();
		sda_h <= 1'b1;
		tick(4);
		scl_h <= 1'b1;
		tick(4);
		sda_h <= 1'b0;
		tick(4);
		scl_h <= 1'b0;
		tick(4);
	endtask : start_cond

	task automatic stop_cond();
		sda_h <= 1'b0;
		tick(4);
		scl_h <= 1'b1;
		tick(4);
		sda_h <= 1'b1;
		tick(4);
	endtask : stop_cond

	task automatic send_byte(input logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(v[i], r);
		bit_io(1'b1, r);
		chk("ack", 16'(r), 16'h0000);
	endtask : send_byte

	task automatic reg_write(input logic [7:0] off, input logic [7:0] v);
		start_cond();
		send_byte({ADDR, 1'b0});
		send_byte(off);
		send_byte(v);
		stop_cond();
	endtask : reg_write

	task automatic check_reg(input string what, input logic [7:0] off, input logic [7:0] exp);
		logic [7:0] v;
		logic r;
		start_cond();
		send_byte({ADDR, 1'b0});
		send_byte(off);
		start_cond();
		send_byte({ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
		bit_io(1'b1, r);
		stop_cond();
		chk(what, 16'(v), 16'(exp));
	endtask : check_reg

	// bounded wait for the shutdown output
	task automatic wait_trip(input int n);
		for (int i = 0; i < n && pwm_tristate !== 1'b1; i++) tick(1);
	endtask : wait_trip

	task automatic toggle_enable();
		enable_in <= 1'b0;
		tick(4);
		chk("power_good after enable loss", 16'(power_good_out), 16'h0000);
		chk("power_good_oe after enable loss", 16'(power_good_oe), 16'h0001);
		chk("pwm released", 16'(pwm_tristate), 16'h0000);
		enable_in <= 1'b1;
		tick(4);
		check_reg("flags after enable toggle", REG_FAULT_FLAGS, 8'h00);
	endtask : toggle_enable

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	initial begin
		tick(95000);
		bad_count++;
		$display("BAD watchdog expected end seen hang");
		complete_run();
	end

	initial begin
		tick(16);
		rst <= 1'b0;
		tick(2);
		check_reg("protection_enables", REG_PROTECTION_ENABLES, RST_PROTECTION_ENABLES);
		check_reg("phase_limit_gain_a", REG_PHASE_LIMIT_GAIN_A, RST_CONFIG);
		reg_write(REG_FAULT_FLAGS, 8'hff);
		check_reg("fault_flags", REG_FAULT_FLAGS, 8'h00);
		check_reg("unmapped", 8'h40, 8'h00);
		reg_write(REG_PHASE_LIMIT_GAIN_A, 8'ha5);
		reg_write(REG_PHASE_LIMIT_GAIN_B, 8'h3c);
		tick(2);
		chk("phase_gain", phase_gain, 16'h3ca5);
		check_reg("phase_limit_gain_b", REG_PHASE_LIMIT_GAIN_B, 8'h3c);
		reg_write(REG_TOTAL_CURRENT_TRIP_LEVEL, 8'h10);
		$display("test registers done");
		// bring-up: nothing converts before power good
		enable_in <= 1'b1;
		tick(200);
		chk("starts before power good", 16'(starts), 16'h0000);
		at_ref <= 1'b1;
		tick(4);
		chk("power_good up", 16'(power_good_out), 16'h0001);
		at_ref <= 1'b0;
		tick(4);
		chk("power_good latched", 16'(power_good_out), 16'h0001);
		at_ref <= 1'b1;
		tick(1700);
		chk("current interval", 16'(cur_gap), 16'(CURRENT_PERIOD_CYC));
		check_reg("total_current_result", REG_TOTAL_CURRENT_RESULT, 8'h20);
		check_reg("output_voltage_result", REG_OUTPUT_VOLTAGE_RESULT, 8'h50);
		check_reg("temperature_result", REG_TEMPERATURE_RESULT, 8'h30);
		codes[0] <= 8'h28;
		reg_write(REG_TOTAL_CURRENT_AVERAGING, 8'h03);
		tick(4600);
		check_reg("averaged current", REG_TOTAL_CURRENT_RESULT, 8'h28);
		$display("test scheduler done");
		// per-phase limiting
		over <= 8'h05;
		tick(8);
		chk("phase_block", 16'(phase_block), 16'h0005);
		chk("power_good while limiting", 16'(power_good_out), 16'h0001);
		check_reg("phase_limit_flags", REG_PHASE_LIMIT_FLAGS, 8'h05);
		reg_write(REG_PHASE_LIMIT_DISABLE, 8'h01);
		tick(2);
		chk("phase_block disabled", 16'(phase_block), 16'h0000);
		over <= 8'h00;
		tick(8);
		check_reg("phase_limit_flags clear", REG_PHASE_LIMIT_FLAGS, 8'h00);
		reg_write(REG_PHASE_LIMIT_DISABLE, 8'h00);
		$display("test phase limit done");
		// shutdown disabled: at-level codes are no fault, over-level sets flags only
		reg_write(REG_PROTECTION_ENABLES, 8'h0b);
		codes <= {TEMP_SHUTDOWN_CODE, 8'h50, 8'h40};
		tick(1800);
		check_reg("flags at level", REG_FAULT_FLAGS, 8'h00);
		codes <= {TEMP_OVER, 8'h50, 8'h41};
		tick(1800);
		chk("pwm with shutdown off", 16'(pwm_tristate), 16'h0000);
		check_reg("flags shutdown off", REG_FAULT_FLAGS, 8'h14);
		codes <= {8'h30, 8'h50, 8'h20};
		toggle_enable();
		$display("test flags only done");
		// temperature shutdown
		reg_write(REG_PROTECTION_ENABLES, RST_PROTECTION_ENABLES);
		codes[2] <= TEMP_OVER;
		wait_trip(3000);
		chk("pwm temp fault", 16'(pwm_tristate), 16'h0001);
		chk("power_good temp fault", 16'(power_good_out), 16'h0000);
		codes[2] <= 8'h30;
		tick(1800);
		chk("temp fault latched", 16'(pwm_tristate), 16'h0001);
		check_reg("flags temp fault", REG_FAULT_FLAGS, 8'h10);
		toggle_enable();
		$display("test temp shutdown done");
		// total current: a short excursion must not trip the longest deglitch
		reg_write(REG_TOTAL_CURRENT_DEGLITCH, 8'h03);
		codes[0] <= 8'h41;
		tick(300);
		codes[0] <= 8'h20;
		tick(1500);
		chk("no trip on short excursion", 16'(pwm_tristate), 16'h0000);
		codes[0] <= 8'h41;
		wait_trip(2500);
		chk("pwm current fault", 16'(pwm_tristate), 16'h0001);
		chk("power_good current fault", 16'(power_good_out), 16'h0000);
		codes[0] <= 8'h20;
		check_reg("flags current fault", REG_FAULT_FLAGS, 8'h04);
		chk("fast current interval", 16'(cur_gap), 16'(CURRENT_FAST_CYC));
		toggle_enable();
		$display("test current shutdown done");
		complete_run();
	end
endmodule : fault_monitor_adc_test
